// file: rtl/line_scan_binary_readout.sv
`timescale 1ns/1ps
`include "line_scan_defs.svh"

// Overview of operation
// - Line is 11 segments of 64 pixels
// - Shift register selects pixels one by one
// - Output one if brighter, zero if darker
// - Reference tracks background; compare raw pixel
module line_scan_binary_readout
  import line_scan_pkg::*;
#(
  parameter int SEG_COUNT = `SEG_COUNT,
  parameter int SEG_PIXELS = `SEG_PIXELS,
  parameter int VIDEO_W = `VIDEO_W
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic LINE_START_PULSE,
  input wire logic [VIDEO_W-1:0] PIXEL_VIDEO,
  output logic BINARY_VIDEO_OUT,
  output logic LINE_ACTIVE,
  output logic [`PIX_IDX_W-1:0] PIXEL_INDEX
);

  localparam int LINE_PIXELS = SEG_COUNT * SEG_PIXELS;
  localparam logic [`PIX_IDX_W-1:0] LAST_PIX = `PIX_IDX_W'(LINE_PIXELS - 1);

  scan_state_t state_ff;
  logic [LINE_PIXELS-1:0] select_ff;
  logic [`PIX_IDX_W-1:0] index_ff;
  logic [VIDEO_W-1:0] ref_ff;
  logic [VIDEO_W-1:0] nxt_ref;
  logic brighter;

  // Readout state: start pulse opens a line, last pixel closes it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= IDLE;
    end else if (LINE_START_PULSE) begin
      state_ff <= READOUT;
    end else if (state_ff == READOUT && select_ff[LINE_PIXELS-1]) begin
      state_ff <= IDLE;
    end
  end

  // One-hot select token walks the cascaded segments per clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      select_ff <= '0;
    end else if (LINE_START_PULSE) begin
      select_ff <= {{(LINE_PIXELS-1){1'b0}}, 1'b1};
    end else begin
      select_ff <= {select_ff[LINE_PIXELS-2:0], 1'b0};
    end
  end

  // Pixel index of the element now selected
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      index_ff <= '0;
    end else if (LINE_START_PULSE) begin
      index_ff <= '0;
    end else if (state_ff == READOUT && index_ff != LAST_PIX) begin
      index_ff <= index_ff + `PIX_IDX_W'(1);
    end
  end

  // Background reference follows the video with a first order lag
  always_comb begin
    nxt_ref = ref_ff;
    if (PIXEL_VIDEO > ref_ff) begin
      nxt_ref = ref_ff + VIDEO_W'((PIXEL_VIDEO - ref_ff) >> `TRACK_SHIFT);
    end else begin
      nxt_ref = ref_ff - VIDEO_W'((ref_ff - PIXEL_VIDEO) >> `TRACK_SHIFT);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_ff <= `REF_RESET;
    end else if (state_ff == READOUT || LINE_START_PULSE) begin
      ref_ff <= nxt_ref;
    end
  end

  // Unmodified pixel compared against the tracking reference
  assign brighter = PIXEL_VIDEO > ref_ff;

  // Registered outputs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BINARY_VIDEO_OUT <= 1'b0;
      LINE_ACTIVE <= 1'b0;
      PIXEL_INDEX <= '0;
    end else begin
      BINARY_VIDEO_OUT <= (state_ff == READOUT) && brighter;
      LINE_ACTIVE <= state_ff == READOUT;
      PIXEL_INDEX <= index_ff;
    end
  end

endmodule : line_scan_binary_readout

// file: rtl/line_scan_defs.svh
`ifndef LINE_SCAN_DEFS_SVH
`define LINE_SCAN_DEFS_SVH

// Line geometry
`define SEG_COUNT 11
`define SEG_PIXELS 64
`define LINE_PIXELS 704
// Pixel index width
`define PIX_IDX_W 10
// Video sample width and reference tracking shift
`define VIDEO_W 8
`define TRACK_SHIFT 3
// Reset value of the background reference
`define REF_RESET 8'h00

`endif

// file: rtl/line_scan_pkg.sv
package line_scan_pkg;
  typedef enum logic [0:0] {
    IDLE,
    READOUT
  } scan_state_t;
endpackage : line_scan_pkg

// file: testbench/line_scan_binary_readout_asserts.sv
`timescale 1ns/1ps
module scan_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic LINE_START_PULSE,
  input wire logic BINARY_VIDEO_OUT,
  input wire logic LINE_ACTIVE,
  input wire logic [9:0] PIXEL_INDEX
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Pixel order, line end, quiet output
  sequence s_run; !LINE_START_PULSE ##1 LINE_ACTIVE; endsequence
  property p_go; LINE_START_PULSE |-> ##2 LINE_ACTIVE && PIXEL_INDEX == 0; endproperty
  property p_step; s_run ##0 PIXEL_INDEX < 703 |=> PIXEL_INDEX == $past(PIXEL_INDEX) + 1;
  endproperty
  property p_end; s_run ##0 PIXEL_INDEX == 703 |=> !LINE_ACTIVE; endproperty
  property p_idle; !LINE_ACTIVE |-> !BINARY_VIDEO_OUT; endproperty
  a_go: assert property (p_go) else $error("late line start");
  a_step: assert property (p_step) else $error("pixel skipped");
  a_end: assert property (p_end) else $error("line too long");
  a_idle: assert property (p_idle) else $error("bit outside line");
endmodule : scan_chk
bind line_scan_binary_readout scan_chk u_chk (.*);

// file: testbench/scan_ctrl_model.sv
`timescale 1ns/1ps
// Controller: one start pulse, random pixels
module scan_ctrl_model (
  input wire logic CLK,
  output logic LINE_START_PULSE = 1'h0,
  output logic [7:0] PIXEL_VIDEO = 8'h00
);
  int seed = 32'h691b;
  int n;
  // Drive just after each edge
  always @(posedge CLK) begin
    LINE_START_PULSE <= #1 (++n == 7);
    PIXEL_VIDEO <= #1 8'($random(seed));
  end
endmodule : scan_ctrl_model

// file: testbench/tb_line_scan_binary_readout.sv
`timescale 1ns/1ps
module tb_line_scan_binary_readout;
  logic CLK = 0, ARST_N = 0, LINE_START_PULSE, BINARY_VIDEO_OUT, LINE_ACTIVE;
  logic [7:0] PIXEL_VIDEO;
  logic [9:0] PIXEL_INDEX;
  logic [11:0] e;
  wire [11:0] seen = {LINE_ACTIVE, BINARY_VIDEO_OUT, PIXEL_INDEX};
  int fail_count, checked, cyc, rf, vv;
  always #10 CLK = ~CLK;
  line_scan_binary_readout u_dut (.*);
  scan_ctrl_model u_ctrl (.*);
  task automatic summarize;
    $display("%0d checked, %0d failed", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Hang guard
  always @(posedge CLK) if (++cyc > 900) begin fail_count++; summarize(); end
  // One full line, every pixel against the model
  initial begin
    repeat (5) @(posedge CLK);
    #1 ARST_N = 1;
    @(posedge CLK iff LINE_START_PULSE);
    vv = PIXEL_VIDEO;
    rf += (vv - rf) / 8;
    for (int k = 0; k < 704; k++) begin
      @(posedge CLK);
      vv = PIXEL_VIDEO;
      e = {1'b1, 1'(vv > rf), 10'(k)};
      rf += (vv - rf) / 8;
      #1 checked++;
      if (seen !== e) begin
        fail_count++;
        $display("unexpected pixel exp %h got %h", e, seen);
      end
    end
    @(posedge CLK);
    #1 checked++;
    if (seen[11:10] !== 2'b00) begin
      fail_count++;
      $display("unexpected line end exp 0 got %b", seen[11:10]);
    end
    summarize();
  end
endmodule : tb_line_scan_binary_readout
